//--- gpv_pin_model.sv
// Model of the external pins with pull-ups
`timescale 1ns/1ps
module gpv_pin_model #(
	parameter int PINS = 8
) (
	input wire logic sys_clk,
	input wire logic [PINS-1:0] extVal,
	input wire logic [PINS-1:0] extOn,
	input wire logic [PINS-1:0] padOut,
	input wire logic [PINS-1:0] padOeN,
	input wire logic [PINS-1:0] pullHighEnable,
	output logic [PINS-1:0] padIn
);
	logic [PINS-1:0] float_r = '0;
	// Undriven pins without pull-up change every cycle
	always_ff @(posedge sys_clk) begin
		float_r <= ~float_r;
	end
	assign padIn = (~padOeN & padOut) | (padOeN & extOn & extVal) | (padOeN & ~extOn & (pullHighEnable | float_r));
endmodule

//--- gpv_pin_sense.sv
// Per-pin synchroniser, inversion, buffer gating and sense detector
`timescale 1ns/1ps
module gpv_pin_sense
	import gpv_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic padIn,
	input wire logic invertEnable,
	input wire logic [2:0] inputSenseSelect,
	output logic levelOut,
	output logic senseHit
);
	logic sync1_r;
	logic sync2_r;
	logic prev_r;
	wire bufOn = (inputSenseSelect != GPV_SENSE_BUF_OFF);
	wire cur = sync2_r ^ invertEnable;
	wire rise = cur & ~prev_r;
	wire fall = ~cur & prev_r;

	// Two-stage synchroniser, held while the buffer is off
	// synchronise pin
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
		end else if (bufOn) begin
			sync1_r <= padIn;
			sync2_r <= sync1_r;
			prev_r <= cur;
		end
	end

	assign levelOut = bufOn ? cur : 1'b0;

	// Sense decode
	// sense decode
	always_comb begin
		unique case (inputSenseSelect)
			GPV_SENSE_ANY_EDGE: senseHit = rise | fall;
			GPV_SENSE_RISE: senseHit = rise;
			GPV_SENSE_FALL: senseHit = fall;
			GPV_SENSE_LOW: senseHit = ~cur;
			default: senseHit = 1'b0;
		endcase
	end
endmodule

//--- gpv_pkg.sv
// Package with register map, field layout and reset values of the port input/sense block
// Summary of operation
// - Pin-level read returns synchronised pin levels
// - Disabled input buffer stops sampling that pin
// - Writing one to pin-level toggles output bit
// - Sense match sets the pin event flag
// - Writing one clears flag, zero keeps it
// - Eight config registers; bit 7 inverts I/O
// - Config bit 3 drives pull-up enable output
// - Sense field: off, both, rise, fall, disabled, low
// - Fast alias block maps four registers at 0-3
// - Alias flags are the main flags, set by any sense match
// - Alias pin-level write toggles alias output
// - Direction bit one makes pin an output
// - Output level drives pin only when output
package gpv_pkg;
	// ----------------------------------------
	// Register indices (byte address = index * 4)
	// ----------------------------------------
	localparam logic [7:0] GPV_FAST_DIR_IDX = 8'h00;
	localparam logic [7:0] GPV_FAST_OUT_IDX = 8'h01;
	localparam logic [7:0] GPV_FAST_IN_IDX = 8'h02;
	localparam logic [7:0] GPV_FAST_FLAG_IDX = 8'h03;
	localparam logic [7:0] GPV_DIR_IDX = 8'h20;
	localparam logic [7:0] GPV_OUT_IDX = 8'h24;
	localparam logic [7:0] GPV_IN_IDX = 8'h08;
	localparam logic [7:0] GPV_FLAG_IDX = 8'h09;
	localparam logic [7:0] GPV_CFG_IDX = 8'h10;
	localparam logic [7:0] GPV_IRQ_EN_IDX = 8'h30;
	localparam logic [7:0] GPV_IRQ_CLR_IDX = 8'h31;
	localparam int GPV_PINS = 8;
	// ----------------------------------------
	// Config field positions and reset values
	// ----------------------------------------
	localparam int GPV_INV_BIT = 7;
	localparam int GPV_PULL_BIT = 3;
	localparam int GPV_SENSE_MSB = 2;
	localparam logic [7:0] GPV_CFG_MASK = 8'h8F;
	localparam logic [7:0] GPV_RESET_BYTE = 8'h00;
	localparam logic [7:0] GPV_IRQ_EN_RESET = 8'hFF;
	typedef enum logic [2:0] {
		GPV_SENSE_OFF_BUF_ON = 3'h0,
		GPV_SENSE_ANY_EDGE = 3'h1,
		GPV_SENSE_RISE = 3'h2,
		GPV_SENSE_FALL = 3'h3,
		GPV_SENSE_BUF_OFF = 3'h4,
		GPV_SENSE_LOW = 3'h5
	} gpv_sense_t;
endpackage

//--- gpv_port.sv
// Top of the port input/sense block with Wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
module gpv_port
	import gpv_pkg::*;
#(
	parameter int PINS = GPV_PINS
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	output logic wb_ack_o,
	input wire logic [PINS-1:0] padIn,
	output logic [PINS-1:0] padOut,
	output logic [PINS-1:0] padOeN,
	output logic [PINS-1:0] pullHighEnable,
	output logic portIrq
);
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] dir_r;
	logic [7:0] dir_nxt;
	logic [7:0] outLvl_r;
	logic [7:0] outLvl_nxt;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	logic [7:0] irqEn_r;
	logic [7:0] irqEn_nxt;
	logic [7:0] cfg_r [PINS];
	logic [PINS-1:0] padOut_r;
	logic [PINS-1:0] padOeN_r;
	logic [PINS-1:0] pull_r;
	logic irq_r;

	// ----------------------------------------
	// Bus response state
	// ----------------------------------------
	logic ack_r;
	logic [31:0] rdat_r;

	// ----------------------------------------
	// Per-pin signals
	// ----------------------------------------
	logic [7:0] pinLevel;
	logic [7:0] hit;
	wire [PINS-1:0] invBit;
	wire [PINS-1:0] pullBit;

	// ----------------------------------------
	// Config field split
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : gCfg
			// Invert and pull-up bits of each pin
			assign invBit[g] = cfg_r[g][GPV_INV_BIT];
			assign pullBit[g] = cfg_r[g][GPV_PULL_BIT];
		end
	endgenerate

	// ----------------------------------------
	// Per-pin sense logic
	// ----------------------------------------
	generate
		for (g = 0; g < PINS; g++) begin : gPin
			// Synchroniser, inversion and sense detector of one pin
			gpv_pin_sense uSense (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.padIn(padIn[g]),
				.invertEnable(invBit[g]),
				.inputSenseSelect(cfg_r[g][GPV_SENSE_MSB:0]),
				.levelOut(pinLevel[g]),
				.senseHit(hit[g])
			);
		end
		for (g = PINS; g < 8; g++) begin : gPad
			// Lanes beyond the pin count read zero and never flag
			assign pinLevel[g] = 1'b0;
			assign hit[g] = 1'b0;
		end
	endgenerate

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Word index and request qualifiers
	wire [7:0] idx = wb_adr_i[9:2];
	wire req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];

	// ----------------------------------------
	// Address match
	// ----------------------------------------
	// alias decode
	wire hitDir = (idx == GPV_DIR_IDX) | (idx == GPV_FAST_DIR_IDX);
	wire hitOut = (idx == GPV_OUT_IDX) | (idx == GPV_FAST_OUT_IDX);
	wire hitIn = (idx == GPV_IN_IDX) | (idx == GPV_FAST_IN_IDX);
	wire hitFlag = (idx == GPV_FLAG_IDX) | (idx == GPV_FAST_FLAG_IDX);
	// Config window and interrupt control words
	wire hitCfg = (idx >= GPV_CFG_IDX) && (idx < GPV_CFG_IDX + 8'(PINS));
	wire [7:0] cfgSel = idx - GPV_CFG_IDX;
	wire [2:0] cfgPin = cfgSel[2:0];
	wire hitEn = (idx == GPV_IRQ_EN_IDX);
	wire hitClr = (idx == GPV_IRQ_CLR_IDX);

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------
	// One strobe per register group
	wire wrDir = wr & hitDir;
	wire wrOut = wr & hitOut;
	wire wrIn = wr & hitIn;
	wire wrFlag = wr & hitFlag;
	wire wrCfg = wr & hitCfg;
	wire wrEn = wr & hitEn;
	wire wrClr = wr & hitClr;
	wire [7:0] clrMask = (wrFlag | wrClr) ? wd : 8'h00;

	// ----------------------------------------
	// Read selection
	// ----------------------------------------
	// Config byte of the addressed pin, reserved bits zero
	wire [7:0] cfgRd = hitCfg ? cfg_r[cfgPin] & GPV_CFG_MASK : 8'h00;
	// Each term is zero unless its word is addressed
	wire [7:0] rdDir = {8{hitDir}} & dir_r;
	wire [7:0] rdOut = {8{hitOut}} & outLvl_r;
	wire [7:0] rdIn = {8{hitIn}} & pinLevel;
	wire [7:0] rdFlag = {8{hitFlag}} & flags_r;
	wire [7:0] rdEn = {8{hitEn}} & irqEn_r;
	// Matches are exclusive, so the terms merge by OR
	wire [7:0] rdByte = rdDir | rdOut | rdIn | rdFlag | rdEn | cfgRd;
	wire [31:0] rdWord = {24'h00_0000, rdByte};

	// ----------------------------------------
	// Bus response
	// ----------------------------------------
	// Acknowledge one cycle after a request is taken
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// Read data captured together with the acknowledge
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdat_r <= 32'h0000_0000;
		end else begin
			rdat_r <= rdWord;
		end
	end

	// ----------------------------------------
	// Direction register
	// ----------------------------------------
	// Next direction value
	always_comb begin
		dir_nxt = dir_r;
		if (wrDir) begin
			dir_nxt = wd;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			dir_r <= GPV_RESET_BYTE;
		end else begin
			dir_r <= dir_nxt;
		end
	end

	// ----------------------------------------
	// Output level register
	// ----------------------------------------
	// Next value: direct write, or toggle through a pin-level word
	// toggle output
	always_comb begin
		outLvl_nxt = outLvl_r;
		if (wrOut) begin
			outLvl_nxt = wd;
		end else if (wrIn) begin
			outLvl_nxt = outLvl_r ^ wd;
		end
	end

	// Output level register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			outLvl_r <= GPV_RESET_BYTE;
		end else begin
			outLvl_r <= outLvl_nxt;
		end
	end

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	// Sticky flags per lane, a new event wins over a clear
	// flag set
	generate
		for (g = 0; g < 8; g++) begin : gFlag
			assign flags_nxt[g] = hit[g] | (flags_r[g] & ~clrMask[g]);
		end
	endgenerate

	// Flag register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			flags_r <= GPV_RESET_BYTE;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// ----------------------------------------
	// Interrupt enable
	// ----------------------------------------
	// Next enable mask
	always_comb begin
		irqEn_nxt = irqEn_r;
		if (wrEn) begin
			irqEn_nxt = wd;
		end
	end

	// Enable mask, every pin enabled out of reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irqEn_r <= GPV_IRQ_EN_RESET;
		end else begin
			irqEn_r <= irqEn_nxt;
		end
	end

	// ----------------------------------------
	// Pin configuration
	// ----------------------------------------
	// per-pin config
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < PINS; i++) begin
				cfg_r[i] <= GPV_RESET_BYTE;
			end
		end else if (wrCfg) begin
			cfg_r[cfgPin] <= wd & GPV_CFG_MASK;
		end
	end

	// ----------------------------------------
	// Pad drive and pull-up
	// ----------------------------------------
	generate
		for (g = 0; g < PINS; g++) begin : gDrive
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					padOut_r[g] <= 1'b0;
					padOeN_r[g] <= 1'b1;
				end else begin
					padOut_r[g] <= outLvl_r[g] ^ invBit[g];
					padOeN_r[g] <= ~dir_r[g];
				end
			end
			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					pull_r[g] <= 1'b0;
				end else begin
					pull_r[g] <= pullBit[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	// Pending events that are enabled
	wire [7:0] pending = flags_r & irqEn_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |pending;
		end
	end

	// ----------------------------------------
	// Output ports
	// ----------------------------------------
	// Every output comes straight from a register
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign padOut = padOut_r;
	assign padOeN = padOeN_r;
	assign pullHighEnable = pull_r;
	assign portIrq = irq_r;
endmodule

//--- gpv_port_properties.sv
// Checker of bus and pin outputs of the port block
`timescale 1ns/1ps
module gpv_port_properties #(
	parameter int PINS = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_we_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic [PINS-1:0] padOut,
	input wire logic [PINS-1:0] padOeN,
	input wire logic [PINS-1:0] pullHighEnable,
	input wire logic portIrq
);
	// Request decode
	wire logic req = wb_cyc_i && wb_stb_i;
	wire logic wr = req && wb_we_i;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	ack_resp_a: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
	ack_cause_a: assert property (wb_ack_o |-> $past(req)) else $error("ack spurious");
	rdata_top_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("data high");
	out_write_a: assert property ($changed(padOut) |-> $past(wr) || $past(wr, 2)) else $error("out");
	oe_write_a: assert property ($changed(padOeN) |-> $past(wr) || $past(wr, 2)) else $error("oe");
	pull_write_a: assert property ($changed(pullHighEnable) |-> $past(wr) || $past(wr, 2)) else $error("pull");
	irq_fall_a: assert property ($fell(portIrq) |-> $past(wr) || $past(wr, 2) || $past(wr, 3)) else $error("irq");
	cover property (wr && wb_ack_o);
	cover property ($rose(portIrq));
	cover property ($fell(padOeN[0]));
endmodule
bind gpv_port gpv_port_properties #(.PINS(PINS)) u_gpv_port_properties(.sys_clk(sys_clk), .rst_n(rst_n),
	.wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.padOut(padOut), .padOeN(padOeN), .pullHighEnable(pullHighEnable), .portIrq(portIrq));

//--- tb_gpv_port.sv
// Testbench of the port input/sense block
`timescale 1ns/1ps
module tb_gpv_port;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] adr = '0, dat = '0, q, dOut;
	logic we = 1'b0, stb = 1'b0, cyc = 1'b0, ack, irq, fe, re;
	logic [7:0] extVal = 8'hA5, extOn = 8'hFF, padIn, padOut, padOeN, pull;
	int err_total = 0, num_checks = 0, cycCnt = 0;
	gpv_port u_gpv_port(.sys_clk(sys_clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dOut),
		.wb_we_i(we), .wb_sel_i(4'hF), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_ack_o(ack), .padIn(padIn),
		.padOut(padOut), .padOeN(padOeN), .pullHighEnable(pull), .portIrq(irq));
	gpv_pin_model u_gpv_pin_model(.sys_clk(sys_clk), .extVal(extVal), .extOn(extOn), .padOut(padOut),
		.padOeN(padOeN), .pullHighEnable(pull), .padIn(padIn));
	// Clock and timeout
	initial forever #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycCnt++;
		if (cycCnt == 5000) begin
			err_total++;
			summarize();
		end
	end
	task summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Single classic Wishbone cycle
	task wb(input logic [7:0] a, input logic w, input logic [7:0] d);
		adr <= {22'h0, a, 2'h0};
		we <= w;
		dat <= {24'h0, d};
		cyc <= 1'b1;
		stb <= 1'b1;
		do @(posedge sys_clk); while (ack !== 1'b1);
		q = dOut;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge sys_clk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		wb(a, 1'b0, 8'h00);
		chk(q, {24'h0, e});
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		chk({padOeN, padOut, pull, 7'h0, irq}, 32'hFF000000);
		rd(8'h09, 8'h00);
		rd(8'h08, 8'hA5);
		extOn <= 8'hFD;
		wb(8'h11, 1'b1, 8'h08);
		wb(8'h12, 1'b1, 8'h04);
		wb(8'h13, 1'b1, 8'h80);
		repeat (4) @(posedge sys_clk);
		rd(8'h08, 8'hAB);
		chk({24'h0, pull}, 32'h02);
		rd(8'h13, 8'h80);
		wb(8'h00, 1'b1, 8'hFF);
		wb(8'h08, 1'b1, 8'h0F);
		chk({16'h0, padOeN, padOut}, 32'h07);
		wb(8'h02, 1'b1, 8'h03);
		rd(8'h01, 8'h0C);
		chk({16'h0, padOeN, padOut}, 32'h04);
		wb(8'h00, 1'b1, 8'h00);
		rd(8'h3F, 8'h00);
		for (int c = 0; c < 6; c++) begin
			fe = c == 1 || c == 3 || c == 5;
			re = c == 1 || c == 2 || c == 5;
			wb(8'h10, 1'b1, 8'(c));
			wb(8'h09, 1'b1, 8'hFF);
			extVal[0] <= 1'b0;
			repeat (8) @(posedge sys_clk);
			rd(8'h09, {7'h0, fe});
			chk({31'h0, irq}, {31'h0, fe});
			wb(8'h09, 1'b1, 8'h01);
			extVal[0] <= 1'b1;
			repeat (8) @(posedge sys_clk);
			wb(8'h03, 1'b1, 8'hFE);
			rd(8'h03, {7'h0, re});
		end
		wb(8'h30, 1'b1, 8'h00);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0);
		wb(8'h31, 1'b1, 8'hFF);
		rd(8'h09, 8'h00);
		summarize();
	end
endmodule
